// *** rmcfg_defs.vh ***
// Constants for the regulator mode configuration bank
`ifndef RMCFG_DEFS_VH
`define RMCFG_DEFS_VH
// ****************************************
// Register map
// ****************************************
`define RMCFG_ADDR_STATUS 8'h20
`define RMCFG_ADDR_DISCH 8'h21
`define RMCFG_ADDR_M0B0 8'h22
`define RMCFG_ADDR_M0B1 8'h23
`define RMCFG_ADDR_M0B2 8'h24
`define RMCFG_ADDR_M0B3 8'h25
`define RMCFG_ADDR_M1B0 8'h26
// ****************************************
// Reset values
// ****************************************
`define RMCFG_RST_DISCH 8'h00
`define RMCFG_RST_M0B0 8'h14
`define RMCFG_RST_M0B1 8'h0c
`define RMCFG_RST_M0B2 8'h4f
`define RMCFG_RST_M0B3 8'h39
`define RMCFG_RST_M1B0 8'h1c
// Mode 1 bytes outside this bank, held at their reset values
`define RMCFG_M1_BUTTON 1'b1
`define RMCFG_M1_SYSBUCK 6'h0c
`define RMCFG_M1_ALIVE 4'h4
`define RMCFG_M1_ENABLES 4'hf
`define RMCFG_M1_WATCHDOG 2'h0
`define RMCFG_M1_LINREG 6'h0c
// ****************************************
// Field positions
// ****************************************
`define RMCFG_SHIP_BIT 7
`define RMCFG_SRC_BIT 6
`define RMCFG_BUTTON_BIT 6
`define RMCFG_OFFSET_BIT 5
// ****************************************
// Voltage decode, millivolts
// ****************************************
`define RMCFG_STEP_MV 12'h019
`define RMCFG_OFFSET_MV 12'h4b0
`define RMCFG_CORE_BASE_MV 12'h1f4
`define RMCFG_CORE_LAST 6'h28
`define RMCFG_CORE_CLAMP_MV 12'h5dc
`define RMCFG_CORE_TOP_MV 12'h708
`define RMCFG_SYS_BASE_MV 12'h5dc
`define RMCFG_SYS_LAST 6'h18
`define RMCFG_SYS_CLAMP_MV 12'h834
`define RMCFG_ALIVE_BASE_MV 12'h6a4
`define RMCFG_ALIVE_LAST 6'h08
`define RMCFG_ALIVE_CLAMP_MV 12'h76c
// ****************************************
// Watchdog periods, seconds
// ****************************************
`define RMCFG_WD_16S 7'h10
`define RMCFG_WD_32S 7'h20
`define RMCFG_WD_64S 7'h40
// ****************************************
// Serial target states
// ****************************************
`define RMCFG_ST_IDLE 3'h0
`define RMCFG_ST_ADDR 3'h1
`define RMCFG_ST_ACKA 3'h2
`define RMCFG_ST_WDATA 3'h3
`define RMCFG_ST_ACKW 3'h4
`define RMCFG_ST_RDATA 3'h5
`define RMCFG_ST_ACKR 3'h6
`define RMCFG_BITS 4'h8
`endif

// *** rmcfg_mv_decode.v ***
// Regulator voltage code to millivolt decoder
`timescale 1ns/1ps
`default_nettype none
`include "rmcfg_defs.vh"
module rmcfg_mv_decode #(
  parameter [11:0] BASE_MV = `RMCFG_SYS_BASE_MV,
  parameter [5:0] LAST_CODE = `RMCFG_SYS_LAST,
  parameter [11:0] CLAMP_MV = `RMCFG_SYS_CLAMP_MV,
  parameter HAS_TOP = 0,
  parameter [11:0] TOP_MV = `RMCFG_CORE_TOP_MV
) (
  // Code and offset select
  input wire [5:0] code,
  input wire offset_on,
  // Decoded level
  output reg [11:0] mv
);
  // Linear range, clamp above, optional all-ones special
  always @* begin
    if (HAS_TOP != 0 && code == 6'h3f) begin
      mv = TOP_MV;
    end else if (code > LAST_CODE) begin
      mv = CLAMP_MV;
    end else begin
      mv = BASE_MV + (code * `RMCFG_STEP_MV);
    end
    if (offset_on) begin
      mv = mv + `RMCFG_OFFSET_MV;
    end
  end
endmodule // rmcfg_mv_decode
`default_nettype wire

// *** rmcfg_i2c_target.v ***
// Serial two-wire target: byte engine with register pointer
`timescale 1ns/1ps
`default_nettype none
`include "rmcfg_defs.vh"
module rmcfg_i2c_target #(
  parameter [6:0] TARGET_ADDR = 7'h2a // Arbitrary value
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Pins, raw
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe_n_ff,
  // Register side
  output reg [7:0] ptr_ff,
  input wire [7:0] rd_data,
  output reg wr_stb_ff,
  output reg [7:0] wr_addr_ff,
  output reg [7:0] wr_data_ff
);
  reg scl_m_ff, scl_s_ff, scl_p_ff, sda_m_ff, sda_s_ff, sda_p_ff;
  reg [2:0] state_ff;
  reg [3:0] cnt_ff;
  reg [7:0] sh_ff;
  reg rw_ff, first_ff;
  wire rise = scl_s_ff & ~scl_p_ff;
  wire fall = ~scl_s_ff & scl_p_ff;
  wire start = scl_s_ff & sda_p_ff & ~sda_s_ff;
  wire stop = scl_s_ff & ~sda_p_ff & sda_s_ff;
  // Two-flop synchronisers; edges compare the second stage with a third, delayed flop
  always @(posedge ref_clk) begin
    scl_m_ff <= scl_in;
    sda_m_ff <= sda_in;
    scl_s_ff <= scl_m_ff;
    sda_s_ff <= sda_m_ff;
    scl_p_ff <= scl_s_ff;
    sda_p_ff <= sda_s_ff;
  end
  // Bus protocol; one data byte per pointer step
  always @(posedge ref_clk) begin
    wr_stb_ff <= 1'b0;
    if (reset) begin
      state_ff <= `RMCFG_ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
    end else if (start) begin
      state_ff <= `RMCFG_ST_ADDR;
      cnt_ff <= 4'h0;
      sda_oe_n_ff <= 1'b1;
    end else if (stop) begin
      state_ff <= `RMCFG_ST_IDLE;
      sda_oe_n_ff <= 1'b1;
    end else begin
      case (state_ff)
        `RMCFG_ST_ADDR, `RMCFG_ST_WDATA: begin
          if (rise) begin
            sh_ff <= {sh_ff[6:0], sda_s_ff};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (fall && cnt_ff == `RMCFG_BITS) begin
            cnt_ff <= 4'h0;
            if (state_ff == `RMCFG_ST_ADDR) begin
              if (sh_ff[7:1] == TARGET_ADDR) begin
                sda_oe_n_ff <= 1'b0;
                rw_ff <= sh_ff[0];
                state_ff <= `RMCFG_ST_ACKA;
              end else begin
                state_ff <= `RMCFG_ST_IDLE;
              end
            end else begin
              sda_oe_n_ff <= 1'b0;
              state_ff <= `RMCFG_ST_ACKW;
              first_ff <= 1'b0;
              if (first_ff) begin
                ptr_ff <= sh_ff;
              end else begin
                wr_stb_ff <= 1'b1;
                wr_addr_ff <= ptr_ff;
                wr_data_ff <= sh_ff;
                ptr_ff <= ptr_ff + 8'h01;
              end
            end
          end
        end
        `RMCFG_ST_ACKA, `RMCFG_ST_ACKR: begin
          if (rise && state_ff == `RMCFG_ST_ACKR) begin
            if (sda_s_ff) begin
              state_ff <= `RMCFG_ST_IDLE; // Host NACK ends the read
            end else begin
              ptr_ff <= ptr_ff + 8'h01;
            end
          end else if (fall && (rw_ff || state_ff == `RMCFG_ST_ACKR)) begin
            sda_oe_n_ff <= rd_data[7];
            sh_ff <= {rd_data[6:0], 1'b0};
            cnt_ff <= 4'h1;
            state_ff <= `RMCFG_ST_RDATA;
          end else if (fall) begin
            sda_oe_n_ff <= 1'b1;
            first_ff <= 1'b1;
            state_ff <= `RMCFG_ST_WDATA;
          end
        end
        `RMCFG_ST_ACKW: begin
          if (fall) begin
            sda_oe_n_ff <= 1'b1;
            state_ff <= `RMCFG_ST_WDATA;
          end
        end
        `RMCFG_ST_RDATA: begin
          if (fall && cnt_ff == `RMCFG_BITS) begin
            sda_oe_n_ff <= 1'b1;
            state_ff <= `RMCFG_ST_ACKR;
          end else if (fall) begin
            sda_oe_n_ff <= sh_ff[7];
            sh_ff <= {sh_ff[6:0], 1'b0};
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        default: begin
          sda_oe_n_ff <= 1'b1;
        end
      endcase
    end
  end
endmodule // rmcfg_i2c_target
`default_nettype wire

// *** rmcfg_top.v ***
// Regulator mode configuration bank: registers, mode choice, regulator controls
`timescale 1ns/1ps
`default_nettype none
`include "rmcfg_defs.vh"
module rmcfg_top #(
  parameter [6:0] TARGET_ADDR = 7'h2a // Arbitrary value
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Serial bus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_ff,
  output wire sda_oe_n,
  // Mode selection
  input wire mode_select_pin_a,
  input wire mode_select_pin_b,
  input wire mode_select_bit_a,
  input wire mode_select_bit_b,
  input wire power_button_fall,
  // Regulator power-good, asynchronous
  input wire [3:0] power_good,
  // Regulator controls: core buck, system buck, always-on, system linreg
  output reg active_mode_ff,
  output reg ship_mode_ff,
  output reg [3:0] regulator_enable_ff,
  output reg [3:0] discharge_on_ff,
  output reg [11:0] core_buck_mv_ff,
  output reg [11:0] system_buck_mv_ff,
  output reg [11:0] alive_linreg_mv_ff,
  output reg [11:0] system_linreg_mv_ff,
  output reg [6:0] watchdog_seconds_ff
);
  // ****************************************
  // Register file
  // ****************************************
  reg [7:0] disch_ff, m0b0_ff, m0b1_ff, m0b2_ff, m0b3_ff, m1b0_ff;
  reg [7:0] rd_data;
  reg [3:0] pg_m_ff, pg_s_ff;
  reg pin_a_m_ff, pin_a_s_ff, pin_b_m_ff, pin_b_s_ff;
  reg req_prev_ff;
  reg req_valid_prev_ff;
  wire [7:0] ptr;
  wire wr_stb;
  wire [7:0] wr_addr, wr_data;

  rmcfg_i2c_target #(
    .TARGET_ADDR(TARGET_ADDR)
  ) u_target (
    .ref_clk(ref_clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_n_ff(sda_oe_n),
    .ptr_ff(ptr),
    .rd_data(rd_data),
    .wr_stb_ff(wr_stb),
    .wr_addr_ff(wr_addr),
    .wr_data_ff(wr_data)
  );

  // Register writes, one byte per strobe
  always @(posedge ref_clk) begin
    if (reset) begin
      disch_ff <= `RMCFG_RST_DISCH;
      m0b0_ff <= `RMCFG_RST_M0B0;
      m0b1_ff <= `RMCFG_RST_M0B1;
      m0b2_ff <= `RMCFG_RST_M0B2;
      m0b3_ff <= `RMCFG_RST_M0B3;
      m1b0_ff <= `RMCFG_RST_M1B0;
    end else if (wr_stb) begin
      case (wr_addr)
        `RMCFG_ADDR_DISCH: disch_ff <= wr_data;
        `RMCFG_ADDR_M0B0: m0b0_ff <= wr_data;
        `RMCFG_ADDR_M0B1: m0b1_ff <= wr_data;
        `RMCFG_ADDR_M0B2: m0b2_ff <= wr_data;
        `RMCFG_ADDR_M0B3: m0b3_ff <= wr_data;
        `RMCFG_ADDR_M1B0: m1b0_ff <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped bytes answer zero
  always @* begin
    case (ptr)
      `RMCFG_ADDR_STATUS: rd_data = {pg_s_ff, 4'h0};
      `RMCFG_ADDR_DISCH: rd_data = disch_ff;
      `RMCFG_ADDR_M0B0: rd_data = m0b0_ff;
      `RMCFG_ADDR_M0B1: rd_data = m0b1_ff;
      `RMCFG_ADDR_M0B2: rd_data = m0b2_ff;
      `RMCFG_ADDR_M0B3: rd_data = m0b3_ff;
      `RMCFG_ADDR_M1B0: rd_data = m1b0_ff;
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************
  // Asynchronous inputs
  // ****************************************
  // Two flops each; only the second stage feeds logic
  always @(posedge ref_clk) begin
    pg_m_ff <= power_good;
    pg_s_ff <= pg_m_ff;
    pin_a_m_ff <= mode_select_pin_a;
    pin_a_s_ff <= pin_a_m_ff;
    pin_b_m_ff <= mode_select_pin_b;
    pin_b_s_ff <= pin_b_m_ff;
  end

  // ****************************************
  // Mode choice
  // ****************************************
  // Fields of the group now in force
  wire cur_src = active_mode_ff ? m1b0_ff[`RMCFG_SRC_BIT] : m0b0_ff[`RMCFG_SRC_BIT];
  wire cur_button = active_mode_ff ? `RMCFG_M1_BUTTON : m0b1_ff[`RMCFG_BUTTON_BIT];
  // Pins or register bits, never a mix
  wire [1:0] req_mode = cur_src ? {pin_b_s_ff, pin_a_s_ff}
                                : {mode_select_bit_b, mode_select_bit_a};
  // Settings 2 and 3 live outside this bank, so they do not move the mode
  wire req_valid = ~req_mode[1];
  wire req_change = req_valid && (req_mode[0] != req_prev_ff || !req_valid_prev_ff);

  // Button edge wins over a same-cycle request only while the group's button bit is clear (mode 1 holds it set); only a new request moves off it
  always @(posedge ref_clk) begin
    if (reset) begin
      active_mode_ff <= 1'b0;
      req_prev_ff <= 1'b0;
      req_valid_prev_ff <= 1'b1;
    end else begin
      req_prev_ff <= req_mode[0];
      req_valid_prev_ff <= req_valid;
      if (power_button_fall && !cur_button) begin
        active_mode_ff <= 1'b0;
      end else if (req_change) begin
        active_mode_ff <= req_mode[0];
      end
    end
  end

  // ****************************************
  // Active group fields
  // ****************************************
  wire [5:0] sel_core = active_mode_ff ? m1b0_ff[5:0] : m0b0_ff[5:0];
  wire [5:0] sel_sys = active_mode_ff ? `RMCFG_M1_SYSBUCK : m0b1_ff[5:0];
  wire [3:0] sel_alive = active_mode_ff ? `RMCFG_M1_ALIVE : m0b2_ff[7:4];
  wire [3:0] sel_en = active_mode_ff ? `RMCFG_M1_ENABLES : m0b2_ff[3:0];
  wire [1:0] sel_wd = active_mode_ff ? `RMCFG_M1_WATCHDOG : m0b3_ff[7:6];
  wire [5:0] sel_lin = active_mode_ff ? `RMCFG_M1_LINREG : m0b3_ff[5:0];
  wire sel_ship = active_mode_ff ? m1b0_ff[`RMCFG_SHIP_BIT] : m0b0_ff[`RMCFG_SHIP_BIT];
  wire [11:0] core_mv, sys_mv, alive_mv, lin_mv;

  rmcfg_mv_decode #(
    .BASE_MV(`RMCFG_CORE_BASE_MV),
    .LAST_CODE(`RMCFG_CORE_LAST),
    .CLAMP_MV(`RMCFG_CORE_CLAMP_MV),
    .HAS_TOP(1),
    .TOP_MV(`RMCFG_CORE_TOP_MV)
  ) u_core (
    .code(sel_core),
    .offset_on(1'b0),
    .mv(core_mv)
  );

  rmcfg_mv_decode #(
    .BASE_MV(`RMCFG_SYS_BASE_MV),
    .LAST_CODE(`RMCFG_SYS_LAST),
    .CLAMP_MV(`RMCFG_SYS_CLAMP_MV),
    .HAS_TOP(0),
    .TOP_MV(`RMCFG_CORE_TOP_MV)
  ) u_sysbuck (
    .code({1'b0, sel_sys[4:0]}),
    .offset_on(sel_sys[`RMCFG_OFFSET_BIT]),
    .mv(sys_mv)
  );

  rmcfg_mv_decode #(
    .BASE_MV(`RMCFG_ALIVE_BASE_MV),
    .LAST_CODE(`RMCFG_ALIVE_LAST),
    .CLAMP_MV(`RMCFG_ALIVE_CLAMP_MV),
    .HAS_TOP(0),
    .TOP_MV(`RMCFG_CORE_TOP_MV)
  ) u_alive (
    .code({2'b00, sel_alive}),
    .offset_on(1'b0),
    .mv(alive_mv)
  );

  rmcfg_mv_decode #(
    .BASE_MV(`RMCFG_SYS_BASE_MV),
    .LAST_CODE(`RMCFG_SYS_LAST),
    .CLAMP_MV(`RMCFG_SYS_CLAMP_MV),
    .HAS_TOP(0),
    .TOP_MV(`RMCFG_CORE_TOP_MV)
  ) u_linreg (
    .code({1'b0, sel_lin[4:0]}),
    .offset_on(sel_lin[`RMCFG_OFFSET_BIT]),
    .mv(lin_mv)
  );

  // Watchdog code to seconds
  function [6:0] wd_seconds;
    input [1:0] code;
    begin
      case (code)
        2'h1: wd_seconds = `RMCFG_WD_16S;
        2'h2: wd_seconds = `RMCFG_WD_32S;
        2'h3: wd_seconds = `RMCFG_WD_64S;
        default: wd_seconds = 7'h00;
      endcase
    end
  endfunction

  // ****************************************
  // Registered regulator controls
  // ****************************************
  // Outputs lag the group by one cycle so the analog side sees clean levels
  always @(posedge ref_clk) begin
    if (reset) begin
      sda_out_ff <= 1'b0;
      ship_mode_ff <= 1'b0;
      regulator_enable_ff <= 4'h0;
      discharge_on_ff <= 4'h0;
      core_buck_mv_ff <= 12'h000;
      system_buck_mv_ff <= 12'h000;
      alive_linreg_mv_ff <= 12'h000;
      system_linreg_mv_ff <= 12'h000;
      watchdog_seconds_ff <= 7'h00;
    end else begin
      sda_out_ff <= 1'b0; // Open drain: only the enable moves
      ship_mode_ff <= sel_ship;
      regulator_enable_ff <= sel_en;
      discharge_on_ff <= ~disch_ff[3:0] & ~sel_en;
      core_buck_mv_ff <= core_mv;
      system_buck_mv_ff <= sys_mv;
      alive_linreg_mv_ff <= alive_mv;
      system_linreg_mv_ff <= lin_mv;
      watchdog_seconds_ff <= wd_seconds(sel_wd);
    end
  end
endmodule // rmcfg_top
`default_nettype wire

// *** rmcfg_top_properties.sv ***
// Port-level checks for the regulator mode configuration bank
`timescale 1ns/1ps
`default_nettype none
module rmcfg_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bus pin and regulator controls
  input wire logic sda_out_ff,
  input wire logic sda_oe_n,
  input wire logic ship_mode_ff,
  input wire logic [3:0] regulator_enable_ff,
  input wire logic [3:0] discharge_on_ff,
  input wire logic [11:0] core_buck_mv_ff,
  input wire logic [11:0] system_buck_mv_ff,
  input wire logic [11:0] alive_linreg_mv_ff,
  input wire logic [11:0] system_linreg_mv_ff,
  input wire logic [6:0] watchdog_seconds_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Level sits on the 25 mV grid inside one band
  function automatic bit on_grid(input logic [11:0] v, input int lo, input int hi);
    return v >= lo && v <= hi && (v - lo) % 25 == 0;
  endfunction
  // ****************************************
  // Release of reset and default settling
  // ****************************************
  sequence s_release;
    $fell(reset);
  endsequence
  sequence s_defaults;
    regulator_enable_ff == 4'hf && discharge_on_ff == 4'h0 && core_buck_mv_ff == 12'h3e8 &&
      system_buck_mv_ff == 12'h708 && alive_linreg_mv_ff == 12'h708 && system_linreg_mv_ff == 12'hce4 &&
      watchdog_seconds_ff == 7'h00 && ship_mode_ff == 1'b0;
  endsequence
  AST_RELEASE_QUIET: assert property (s_release |-> sda_oe_n && regulator_enable_ff == 4'h0)
    else $error("outputs not quiet at reset release");
  AST_RESET_DEFAULTS: assert property (s_release |-> ##[1:3] s_defaults)
    else $error("mode 0 defaults missing after reset");
  // Bleed resistor only while its regulator is off
  AST_DISCHARGE_OFF_ONLY: assert property ((discharge_on_ff & regulator_enable_ff) == 4'h0)
    else $error("discharge on while regulator enabled");
  AST_WATCHDOG_SET: assert property (watchdog_seconds_ff inside {7'h00, 7'h10, 7'h20, 7'h40})
    else $error("watchdog period outside the four settings");
  AST_CORE_GRID: assert property (core_buck_mv_ff == 12'h0 || core_buck_mv_ff == 12'h708 || on_grid(core_buck_mv_ff, 500, 1500))
    else $error("core buck level off grid");
  AST_SYSBUCK_GRID: assert property (system_buck_mv_ff == 12'h0 || on_grid(system_buck_mv_ff, 1500, 2100) ||
    on_grid(system_buck_mv_ff, 2700, 3300))
    else $error("system buck level off grid");
  AST_ALIVE_GRID: assert property (alive_linreg_mv_ff == 12'h0 || on_grid(alive_linreg_mv_ff, 1700, 1900))
    else $error("always-on level off grid");
  AST_LINREG_GRID: assert property (system_linreg_mv_ff == 12'h0 || on_grid(system_linreg_mv_ff, 1500, 2100) ||
    on_grid(system_linreg_mv_ff, 2700, 3300))
    else $error("system linreg level off grid");
  // Open drain: the data pin is only ever pulled low
  AST_SDA_PULL_LOW: assert property (sda_out_ff == 1'b0)
    else $error("data pin driven high");
endmodule // rmcfg_checker
bind rmcfg_top rmcfg_checker u_chk (.ref_clk(ref_clk), .reset(reset), .sda_out_ff(sda_out_ff),
  .sda_oe_n(sda_oe_n), .ship_mode_ff(ship_mode_ff), .regulator_enable_ff(regulator_enable_ff),
  .discharge_on_ff(discharge_on_ff), .core_buck_mv_ff(core_buck_mv_ff), .system_buck_mv_ff(system_buck_mv_ff),
  .alive_linreg_mv_ff(alive_linreg_mv_ff), .system_linreg_mv_ff(system_linreg_mv_ff),
  .watchdog_seconds_ff(watchdog_seconds_ff));
`default_nettype wire

// *** rmcfg_host_model.sv ***
// Two-wire bus host model that reaches the bank's serial target
`timescale 1ns/1ps
`default_nettype none
module rmcfg_host_model #(
  parameter [6:0] DEV_ADDR = 7'h2a, // Arbitrary value, matches the target
  parameter int HALF = 8
) (
  // Clock and bus
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl = 1'b1,
  output logic sda_rel = 1'b1
);
  event rd_done;
  logic [7:0] rd_byte;
  // All bus moves land on the falling system clock edge
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Data moves only while the bus clock is low
  task automatic bit_out(input logic b);
    wt(2);
    sda_rel = b;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    wt(2);
    sda_rel = 1'b1;
    wt(HALF);
    scl = 1'b1;
    b = sda;
    wt(HALF);
    scl = 1'b0;
  endtask
  // Start also serves as repeated start
  task automatic start();
    wt(2);
    sda_rel = 1'b1;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_rel = 1'b0;
    wt(HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sda_rel = 1'b0;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_rel = 1'b1;
    wt(HALF);
  endtask
  task automatic byte_out(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
  endtask
  // Single-byte accesses only
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(a);
    byte_out(d);
    stop();
  endtask
  task automatic read(input logic [7:0] a);
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(a);
    start();
    byte_out({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_in(rd_byte[i]);
    bit_out(1'b1);
    stop();
    -> rd_done;
  endtask
endmodule // rmcfg_host_model
`default_nettype wire

// *** regulator_mode_config_bank_test.sv ***
// Self-checking bench for the regulator mode configuration bank
`timescale 1ns/1ps
`default_nettype none
module regulator_mode_config_bank_test;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic mode_select_pin_a = 1'b0, mode_select_pin_b = 1'b0, mode_select_bit_a = 1'b0, mode_select_bit_b = 1'b0;
  logic power_button_fall = 1'b0;
  logic [3:0] power_good = 4'h0;
  wire scl_in, sda_rel, sda_out_ff, sda_oe_n, active_mode_ff, ship_mode_ff;
  wire sda_in = sda_rel & (sda_oe_n | sda_out_ff);
  wire [3:0] enables, discharge;
  wire [11:0] core_mv, sysb_mv, alive_mv, lin_mv;
  wire [6:0] wd_s;
  logic [7:0] m [0:6];
  logic [64:0] qo[$];
  logic [7:0] qr[$];
  logic [15:0] tbl [0:11] = '{16'h223f, 16'h2229, 16'h2228, 16'h2338, 16'h2319, 16'h2480, 16'h249a,
    16'h21f5, 16'h257f, 16'h2580, 16'h25c0, 16'h20ff};
  logic act = 1'b0;
  int err_total = 0, num_checks = 0, seed = 72;
  event out_ev;
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  rmcfg_top uut (.ref_clk(ref_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out_ff(sda_out_ff),
    .sda_oe_n(sda_oe_n), .mode_select_pin_a(mode_select_pin_a), .mode_select_pin_b(mode_select_pin_b),
    .mode_select_bit_a(mode_select_bit_a), .mode_select_bit_b(mode_select_bit_b),
    .power_button_fall(power_button_fall), .power_good(power_good), .active_mode_ff(active_mode_ff),
    .ship_mode_ff(ship_mode_ff), .regulator_enable_ff(enables), .discharge_on_ff(discharge),
    .core_buck_mv_ff(core_mv), .system_buck_mv_ff(sysb_mv), .alive_linreg_mv_ff(alive_mv),
    .system_linreg_mv_ff(lin_mv), .watchdog_seconds_ff(wd_s));
  rmcfg_host_model host (.ref_clk(ref_clk), .sda(sda_in), .scl(scl_in), .sda_rel(sda_rel));
  // ****************************************
  // Expected values and comparisons
  // ****************************************
  function automatic logic [11:0] lin25(input int code, input int base, input int last, input int cap);
    return 12'((code > last) ? cap : base + 25 * code);
  endfunction
  // Mode 1 bytes beyond 26h stay at their reset contents
  function automatic logic [64:0] expect_out();
    logic [7:0] b0, b1, b2, b3;
    logic [11:0] core;
    b0 = act ? m[6] : m[2];
    b1 = act ? 8'h0c : m[3];
    b2 = act ? 8'h4f : m[4];
    b3 = act ? 8'h0c : m[5];
    core = (b0[5:0] == 6'h3f) ? 12'd1800 : lin25(b0[5:0], 500, 40, 1500);
    return {act, b0[7], b2[3:0], ~m[1][3:0] & ~b2[3:0], core,
      lin25(b1[4:0], 1500, 24, 2100) + (b1[5] ? 12'd1200 : 12'd0), lin25(b2[7:4], 1700, 8, 1900),
      lin25(b3[4:0], 1500, 24, 2100) + (b3[5] ? 12'd1200 : 12'd0), (b3[7:6] == 2'b00) ? 7'h00 : 7'h08 << b3[7:6]};
  endfunction
  task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic cmp_out(input logic [64:0] exp, input logic [64:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // Each result takes the oldest pending note
  always @(host.rd_done) cmp_byte(qr.pop_front(), host.rd_byte);
  always @(out_ev) cmp_out(qo.pop_front(),
    {active_mode_ff, ship_mode_ff, enables, discharge, core_mv, sysb_mv, alive_mv, lin_mv, wd_s});
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    qr.push_back(exp);
    host.read(a);
  endtask
  // Settle time covers pin synchronisers and the output register stage
  task automatic out_chk();
    repeat (8) @(negedge ref_clk);
    qo.push_back(expect_out());
    -> out_ev;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write(a, d);
    if (a > 8'h20 && a < 8'h27) m[a - 8'h20] = d;
  endtask
  task automatic do_reset();
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    m = '{8'h00, 8'h00, 8'h14, 8'h0c, 8'h4f, 8'h39, 8'h1c};
    act = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [15:0] op;
    power_good = 4'($random(seed));
    do_reset();
    for (int a = 0; a < 7; a++) rd_chk(8'(8'h20 + a), (a == 0) ? {power_good, 4'h0} : m[a]);
    out_chk();
    $display("test reset_values done");
    for (int i = 0; i < 18; i++) begin
      op = (i < 12) ? tbl[i] : {8'(8'h21 + {$random(seed)} % 5), 8'($random(seed))};
      wr(op[15:8], op[7:0]);
      rd_chk(op[15:8], (op[15:8] == 8'h20) ? {power_good, 4'h0} : m[op[15:8] - 8'h20]);
      out_chk();
    end
    wr(8'h30, 8'h5a);
    rd_chk(8'h30, 8'h00);
    $display("test register_writes done");
    wr(8'h22, m[2] & 8'hbf);
    wr(8'h26, 8'h9f);
    mode_select_bit_a = 1'b1;
    act = 1'b1;
    out_chk();
    mode_select_bit_a = 1'b0;
    mode_select_bit_b = 1'b1;
    out_chk();
    power_button_fall = 1'b1;
    @(negedge ref_clk);
    power_button_fall = 1'b0;
    out_chk();
    mode_select_bit_b = 1'b0;
    act = 1'b0;
    out_chk();
    wr(8'h23, m[3] & 8'hbf);
    mode_select_bit_a = 1'b1;
    power_button_fall = 1'b1;
    @(negedge ref_clk);
    power_button_fall = 1'b0;
    out_chk();
    mode_select_bit_a = 1'b0;
    wr(8'h22, m[2] | 8'h40);
    wr(8'h26, 8'hdf);
    mode_select_pin_a = 1'b1;
    act = 1'b1;
    out_chk();
    mode_select_pin_a = 1'b0;
    act = 1'b0;
    out_chk();
    mode_select_pin_a = 1'b1;
    mode_select_pin_b = 1'b1;
    mode_select_bit_a = 1'b1;
    out_chk();
    $display("test mode_select done");
    mode_select_pin_a = 1'b0;
    mode_select_pin_b = 1'b0;
    mode_select_bit_a = 1'b0;
    do_reset();
    rd_chk(8'h24, 8'h4f);
    out_chk();
    $display("test second_reset done");
    results();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #1000000;
    err_total++;
    results();
  end
endmodule // regulator_mode_config_bank_test
`default_nettype wire
